// ### src/rtc_timer_pkg.sv
package rtc_timer_pkg;

	// system and crystal rates
	localparam int unsigned CLK_HZ   = 100_000_000;
	localparam int unsigned XTAL_HZ  = 32768;
	// pclk cycles per crystal tick, rounded down
	localparam int unsigned XTAL_DIV = CLK_HZ / XTAL_HZ;

	// source clock dividers
	localparam int unsigned DIV_4096 = 8;   // crystal ticks per 4096 Hz tick
	localparam int unsigned DIV_64   = 512; // crystal ticks per 64 Hz tick
	localparam int unsigned DIV_1HZ  = 64;  // 64 Hz ticks per second
	localparam int unsigned DIV_MIN  = 60;  // seconds per minute

	// width of the pulsed interrupt
	localparam int unsigned IRQ_PULSE_NS     = 1000;
	localparam int unsigned IRQ_PULSE_CYCLES = (IRQ_PULSE_NS * (CLK_HZ / 1_000_000) + 999) / 1000;

	// device registers on the link
	localparam logic [1:0] ADDR_CTRL  = 2'h0;
	localparam logic [1:0] ADDR_STAT  = 2'h1;
	localparam logic [1:0] ADDR_COUNT = 2'h2;

	// control register fields
	localparam int unsigned CTRL_RUN_BIT   = 0;
	localparam int unsigned CTRL_SEL_LSB   = 1;
	localparam int unsigned CTRL_IE_BIT    = 3;
	localparam int unsigned CTRL_PULSE_BIT = 4;
	localparam int unsigned STAT_FLAG_BIT  = 0;

	// device reset values: slowest source, stopped, no interrupt
	localparam logic [7:0] CTRL_RESET  = 8'h06;
	localparam logic [7:0] COUNT_RESET = 8'h00;

	// host apb map
	localparam logic [11:0] HOST_CMD_OFS  = 12'h000;
	localparam logic [11:0] HOST_STAT_OFS = 12'h004;
	localparam int unsigned CMD_WDATA_LSB   = 0;
	localparam int unsigned CMD_ADDR_LSB    = 8;
	localparam int unsigned CMD_WRITE_BIT   = 16;
	localparam int unsigned HSTAT_BUSY_BIT  = 0;
	localparam int unsigned HSTAT_IRQ_BIT   = 1;
	localparam int unsigned HSTAT_RDATA_LSB = 8;

	typedef enum logic [1:0] {
		SRC_4096 = 2'b00,
		SRC_64   = 2'b01,
		SRC_1HZ  = 2'b10,
		SRC_MIN  = 2'b11
	} src_sel_t;

	typedef enum logic {
		LS_IDLE = 1'b0,
		LS_WAIT = 1'b1
	} link_state_t;

endpackage

// ### src/rtc_link_if.sv
interface rtc_link_if;
	logic       req_tgl;
	logic       wr;
	logic [1:0] addr;
	logic [7:0] wdata;
	logic       ack_tgl;
	logic [7:0] rdata;
	logic       irq_drv;
	logic       irq_oe;
	logic       irq_n;

	// open-drain interrupt line with pull-up
	assign irq_n = irq_oe ? irq_drv : 1'b1;

	modport dev (
		input  req_tgl,
		input  wr,
		input  addr,
		input  wdata,
		output ack_tgl,
		output rdata,
		output irq_drv,
		output irq_oe
	);

	modport host (
		output req_tgl,
		output wr,
		output addr,
		output wdata,
		input  ack_tgl,
		input  rdata,
		input  irq_n
	);
endinterface

// ### src/sync3.sv
module sync3 #(
	parameter logic INIT = 1'b0
) (
	input  wire logic clk,
	input  wire logic rst_n,
	input  wire logic d,
	output logic      level,
	output logic      change
);
	logic s1_q;
	logic s2_q;
	logic s3_q;

	// a change counts only once stages two and three agree
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s1_q   <= INIT;
			s2_q   <= INIT;
			s3_q   <= INIT;
			level  <= INIT;
			change <= 1'b0;
		end else begin
			s1_q <= d;
			s2_q <= s1_q;
			s3_q <= s2_q;
			if (s2_q == s3_q && s2_q != level) begin
				level  <= s2_q;
				change <= 1'b1;
			end else begin
				change <= 1'b0;
			end
		end
	end
endmodule

// ### src/rtc_timer_dev.sv
// Notes on behaviour
// - 8-bit down counter, four selectable sources
// - count zero halts; 1 to 255 valid
// - at one: set flag, reload, continue
// - count read returns live value
// - reload write loads running counter at once
// - run bit zero stops the countdown
// - host should stop timer before new reload
// - stored reload stays intact for later periods
// - only first period after enable varies
// - first period n..n+1, slow: 1/64 offset
// - nominal period is n source ticks
// - host reads faster than twice source rate
// - host reads count twice, compares
// - flag set by expiry, cleared only by host
// - enabled interrupt follows expiry, mode chosen
// - pulsed mode pulses every expiry regardless
// - level mode holds while flag set
// - unused timer: host picks slowest source
// - sources derived from crystal, async to host
module rtc_timer_dev (
	input  wire logic  pclk,
	input  wire logic  presetn,
	rtc_link_if.dev    link,
	output logic       expiry_flag,
	output logic [7:0] live_count
);
	// crystal divider width, wide enough for XTAL_DIV
	localparam int unsigned XW = 12;
	localparam logic [XW-1:0] XTAL_LAST = XW'(rtc_timer_pkg::XTAL_DIV - 1);
	localparam logic [8:0] PRESC_LAST = 9'(rtc_timer_pkg::DIV_64 - 1);
	localparam logic [2:0] P4096_LAST = 3'(rtc_timer_pkg::DIV_4096 - 1);
	localparam logic [5:0] SEC_LAST = 6'(rtc_timer_pkg::DIV_1HZ - 1);
	localparam logic [5:0] MIN_LAST = 6'(rtc_timer_pkg::DIV_MIN - 1);
	localparam logic [7:0] PULSE_LEN = 8'(rtc_timer_pkg::IRQ_PULSE_CYCLES);

	logic          req_seen;
	logic [XW-1:0] xdiv_q;
	logic          xtal_tick_q;
	logic [8:0]    presc_q;
	logic [5:0]    sec_q;
	logic [5:0]    min_q;
	logic [7:0]    ctrl_q;
	logic [7:0]    reload_q;
	logic [7:0]    count_q;
	logic          flag_q;
	logic [7:0]    pulse_q;
	logic          irq_oe_q;
	logic          irq_drv_q;
	logic          ack_q;
	logic [7:0]    rdata_q;
	logic          skip_q;

	logic                  wr_ctrl;
	logic                  wr_stat;
	logic                  wr_count;
	logic                  run;
	logic                  irq_en;
	logic                  pulse_mode;
	logic                  run_start;
	logic                  tick4096;
	logic                  tick64;
	logic                  tick_sec;
	logic                  tick_min;
	logic                  src_tick;
	logic                  expire;
	logic                  flag_d;
	logic [7:0]            pulse_d;
	rtc_timer_pkg::src_sel_t sel;

	// request toggle from the host crosses here before it acts
	sync3 #(
		.INIT(1'b0)
	) u_req_sync (
		.clk    (pclk),
		.rst_n  (presetn),
		.d      (link.req_tgl),
		.level  (),
		.change (req_seen)
	);

	// write decode; addr and data are held by the host until acked
	always_comb begin
		wr_ctrl  = req_seen && link.wr && link.addr == rtc_timer_pkg::ADDR_CTRL;
		wr_stat  = req_seen && link.wr && link.addr == rtc_timer_pkg::ADDR_STAT;
		wr_count = req_seen && link.wr && link.addr == rtc_timer_pkg::ADDR_COUNT;
	end

	// control fields
	assign run        = ctrl_q[rtc_timer_pkg::CTRL_RUN_BIT];
	assign irq_en     = ctrl_q[rtc_timer_pkg::CTRL_IE_BIT];
	assign pulse_mode = ctrl_q[rtc_timer_pkg::CTRL_PULSE_BIT];
	assign sel        = rtc_timer_pkg::src_sel_t'(ctrl_q[rtc_timer_pkg::CTRL_SEL_LSB +: 2]);
	assign run_start  = wr_ctrl && !run && link.wdata[rtc_timer_pkg::CTRL_RUN_BIT];

	// crystal tick made from pclk; free running, never aligned to the host
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			xdiv_q      <= '0;
			xtal_tick_q <= 1'b0;
		end else if (xdiv_q == XTAL_LAST) begin
			xdiv_q      <= '0;
			xtal_tick_q <= 1'b1;
		end else begin
			xdiv_q      <= xdiv_q + XW'(1);
			xtal_tick_q <= 1'b0;
		end
	end

	// prescaler up to 64 Hz keeps running, so an enable lands mid-tick
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			presc_q <= '0;
		end else if (xtal_tick_q) begin
			presc_q <= (presc_q == PRESC_LAST) ? 9'h000 : presc_q + 9'h001;
		end
	end

	// source ticks, one pclk wide each
	assign tick4096 = xtal_tick_q && presc_q[2:0] == P4096_LAST;
	assign tick64   = xtal_tick_q && presc_q == PRESC_LAST;
	assign tick_sec = tick64 && sec_q == SEC_LAST;
	assign tick_min = tick_sec && min_q == MIN_LAST;

	// on enable slow stages restart, first tick one 64 Hz step after the next;
	// a fast source drops its partial first tick, so the first period is n..n+1
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sec_q  <= '0;
			min_q  <= '0;
			skip_q <= 1'b0;
		end else if (run_start) begin
			sec_q  <= SEC_LAST - 6'h01;
			min_q  <= MIN_LAST;
			skip_q <= !link.wdata[rtc_timer_pkg::CTRL_SEL_LSB + 1];
		end else begin
			if (tick64) begin
				sec_q <= (sec_q == SEC_LAST) ? 6'h00 : sec_q + 6'h01;
			end
			if (tick_sec) begin
				min_q <= (min_q == MIN_LAST) ? 6'h00 : min_q + 6'h01;
			end
			if (run && src_tick) begin
				skip_q <= 1'b0;
			end
		end
	end

	// source clock selection
	always_comb begin
		unique case (sel)
			rtc_timer_pkg::SRC_4096: src_tick = tick4096;
			rtc_timer_pkg::SRC_64:   src_tick = tick64;
			rtc_timer_pkg::SRC_1HZ:  src_tick = tick_sec;
			rtc_timer_pkg::SRC_MIN:  src_tick = tick_min;
		endcase
	end

	// control register; reset picks the slowest source for low power
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_q <= rtc_timer_pkg::CTRL_RESET;
		end else if (wr_ctrl) begin
			ctrl_q <= link.wdata;
		end
	end

	// expiry happens on the tick that finds the counter at one
	assign expire = run && src_tick && !skip_q && count_q == 8'h01 && !wr_count;

	// reload store is separate from the live counter
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			reload_q <= rtc_timer_pkg::COUNT_RESET;
		end else if (wr_count) begin
			reload_q <= link.wdata;
		end
	end

	// countdown; a host write beats a tick in the same cycle, so no corrupt load
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			count_q <= rtc_timer_pkg::COUNT_RESET;
		end else if (wr_count) begin
			count_q <= link.wdata;
		end else if (expire) begin
			count_q <= reload_q;
		end else if (run && src_tick && !skip_q && count_q != 8'h00) begin
			count_q <= count_q - 8'h01;
		end
	end

	// flag: expiry sets, host write of one clears, set wins
	always_comb begin
		if (expire) begin
			flag_d = 1'b1;
		end else if (wr_stat && link.wdata[rtc_timer_pkg::STAT_FLAG_BIT]) begin
			flag_d = 1'b0;
		end else begin
			flag_d = flag_q;
		end
	end

	// pulse timer restarts at each expiry while pulsed mode and the interrupt enable are set, flag state ignored
	always_comb begin
		if (expire && irq_en && pulse_mode) begin
			pulse_d = PULSE_LEN;
		end else if (pulse_q != 8'h00) begin
			pulse_d = pulse_q - 8'h01;
		end else begin
			pulse_d = 8'h00;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			flag_q  <= 1'b0;
			pulse_q <= 8'h00;
		end else begin
			flag_q  <= flag_d;
			pulse_q <= pulse_d;
		end
	end

	// open-drain line pulled low while asserted
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_oe_q  <= 1'b0;
			irq_drv_q <= 1'b0;
		end else begin
			irq_drv_q <= 1'b0;
			if (pulse_mode) begin
				irq_oe_q <= irq_en && pulse_d != 8'h00;
			end else begin
				irq_oe_q <= irq_en && flag_d;
			end
		end
	end

	// link answer: capture read data and toggle the ack on the same edge
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ack_q   <= 1'b0;
			rdata_q <= 8'h00;
		end else if (req_seen) begin
			ack_q <= ~ack_q;
			if (!link.wr) begin
				unique case (link.addr)
					rtc_timer_pkg::ADDR_CTRL:  rdata_q <= ctrl_q;
					rtc_timer_pkg::ADDR_STAT:  rdata_q <= {7'h00, flag_q};
					rtc_timer_pkg::ADDR_COUNT: rdata_q <= count_q;
					default:                   rdata_q <= 8'h00;
				endcase
			end
		end
	end

	// user-side mirrors of the state
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			expiry_flag <= 1'b0;
			live_count  <= 8'h00;
		end else begin
			expiry_flag <= flag_d;
			live_count  <= count_q;
		end
	end

	assign link.ack_tgl = ack_q;
	assign link.rdata   = rdata_q;
	assign link.irq_oe  = irq_oe_q;
	assign link.irq_drv = irq_drv_q;
endmodule

// ### src/rtc_timer_host.sv
module rtc_timer_host (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	rtc_link_if.host         link
);
	logic                       ack_seen;
	logic                       irq_level;
	logic                       req_q;
	logic                       wr_q;
	logic [1:0]                 addr_q;
	logic [7:0]                 wdata_q;
	logic [7:0]                 rd_q;
	rtc_timer_pkg::link_state_t state_q;
	logic                       acc;
	logic                       mapped;
	logic                       cmd_go;

	// ack toggle and interrupt line come from the device
	sync3 #(
		.INIT(1'b0)
	) u_ack_sync (
		.clk    (pclk),
		.rst_n  (presetn),
		.d      (link.ack_tgl),
		.level  (),
		.change (ack_seen)
	);

	sync3 #(
		.INIT(1'b1)
	) u_irq_sync (
		.clk    (pclk),
		.rst_n  (presetn),
		.d      (link.irq_n),
		.level  (irq_level),
		.change ()
	);

	// apb decode; a command only starts at the completing edge
	always_comb begin
		acc    = psel && penable;
		mapped = paddr == rtc_timer_pkg::HOST_CMD_OFS || paddr == rtc_timer_pkg::HOST_STAT_OFS;
		cmd_go = acc && pready && pwrite && paddr == rtc_timer_pkg::HOST_CMD_OFS
			&& state_q == rtc_timer_pkg::LS_IDLE;
	end

	// one wait state; prdata and pslverr are registered with pready
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			prdata  <= 32'h0000_0000;
			pslverr <= 1'b0;
		end else begin
			pready  <= acc && !pready;
			pslverr <= acc && !pready && !mapped;
			prdata  <= 32'h0000_0000;
			if (acc && !pready && paddr == rtc_timer_pkg::HOST_STAT_OFS) begin
				prdata[rtc_timer_pkg::HSTAT_BUSY_BIT]       <= state_q == rtc_timer_pkg::LS_WAIT;
				prdata[rtc_timer_pkg::HSTAT_IRQ_BIT]        <= !irq_level;
				prdata[rtc_timer_pkg::HSTAT_RDATA_LSB +: 8] <= rd_q;
			end
		end
	end

	// link sequencer; a command while busy is dropped
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q <= rtc_timer_pkg::LS_IDLE;
			req_q   <= 1'b0;
			wr_q    <= 1'b0;
			addr_q  <= 2'h0;
			wdata_q <= 8'h00;
			rd_q    <= 8'h00;
		end else begin
			unique case (state_q)
				rtc_timer_pkg::LS_IDLE: begin
					if (cmd_go) begin
						wr_q    <= pwdata[rtc_timer_pkg::CMD_WRITE_BIT];
						addr_q  <= pwdata[rtc_timer_pkg::CMD_ADDR_LSB +: 2];
						wdata_q <= pwdata[rtc_timer_pkg::CMD_WDATA_LSB +: 8];
						req_q   <= ~req_q;
						state_q <= rtc_timer_pkg::LS_WAIT;
					end
				end
				rtc_timer_pkg::LS_WAIT: begin
					if (ack_seen) begin
						if (!wr_q) begin
							rd_q <= link.rdata;
						end
						state_q <= rtc_timer_pkg::LS_IDLE;
					end
				end
			endcase
		end
	end

	assign link.req_tgl = req_q;
	assign link.wr      = wr_q;
	assign link.addr    = addr_q;
	assign link.wdata   = wdata_q;
endmodule

// ### sim/rtc_timer_properties.sv
module rtc_timer_properties (
	input  wire logic       pclk,
	input  wire logic       presetn,
	input  wire logic       req_tgl,
	input  wire logic       wr,
	input  wire logic [1:0] addr,
	input  wire logic [7:0] wdata,
	input  wire logic       ack_tgl,
	input  wire logic       irq_drv,
	input  wire logic       irq_oe,
	input  wire logic       expiry_flag,
	input  wire logic [7:0] live_count
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	// a request and its answer are each one toggle
	sequence s_req;
		$changed(req_tgl);
	endsequence
	sequence s_ack;
		$changed(ack_tgl);
	endsequence
	// no write has reached the counter lately, so any change is a tick
	sequence s_quiet;
		$stable(ack_tgl) && $past(ack_tgl) == $past(ack_tgl, 2);
	endsequence

	// link handshake
	a_ack_after_req: assert property (s_req |-> ##[2:6] s_ack)
		else $error("link ack missing after request");
	a_ack_needs_req: assert property (s_ack |-> $past(req_tgl != ack_tgl))
		else $error("link ack without request");
	a_one_outstanding: assert property (s_req |-> $past(req_tgl == ack_tgl))
		else $error("second request before ack");
	a_req_fields_held: assert property ((req_tgl != ack_tgl && $stable(req_tgl))
		|-> $stable({wr, addr, wdata})) else $error("request fields moved while pending");

	// counter behaviour
	a_zero_halts: assert property ((live_count == 8'h00 && req_tgl == ack_tgl)[*2]
		|=> live_count == 8'h00) else $error("zero count moved");
	a_count_steps: assert property ((s_quiet ##0 $changed(live_count))
		|-> live_count == $past(live_count) - 8'h01 || $past(live_count) == 8'h01)
		else $error("count changed by other than one step");
	a_flag_at_one: assert property ($rose(expiry_flag) |-> live_count == 8'h01)
		else $error("flag set away from count one");
	a_flag_sticky: assert property ($fell(expiry_flag)
		|-> wr && ack_tgl != $past(ack_tgl, 2)) else $error("flag cleared without host write");

	// interrupt pin
	a_irq_from_flag: assert property ($rose(irq_oe)
		|-> expiry_flag || $past(expiry_flag)) else $error("interrupt without expiry");
	a_irq_open_drain: assert property (irq_oe |-> irq_drv == 1'b0)
		else $error("interrupt pin not driven low");
endmodule

// ### sim/testbench.sv
module testbench;
	timeunit 1ns;
	timeprecision 100ps;

	// one 4096 Hz source tick in pclk cycles
	localparam int TICK = rtc_timer_pkg::DIV_4096 * rtc_timer_pkg::XTAL_DIV;

	logic        pclk = 1'b0;
	logic        presetn = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        expiry_flag;
	logic [7:0]  live_count;
	logic [31:0] q;
	logic        err;
	int          cyc = 0;
	int          n_fail = 0;
	int          checked = 0;

	rtc_link_if link ();
	rtc_timer_dev u_rtc_timer_dev (.pclk(pclk), .presetn(presetn), .link(link.dev),
		.expiry_flag(expiry_flag), .live_count(live_count));
	rtc_timer_host u_rtc_timer_host (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .link(link.host));
	rtc_timer_properties u_chk (.pclk(pclk), .presetn(presetn), .req_tgl(link.req_tgl),
		.wr(link.wr), .addr(link.addr), .wdata(link.wdata), .ack_tgl(link.ack_tgl),
		.irq_drv(link.irq_drv), .irq_oe(link.irq_oe), .expiry_flag(expiry_flag),
		.live_count(live_count));

	// clock and a cycle count for period measurement
	always #5 pclk = ~pclk;
	always @(posedge pclk) cyc <= cyc + 1;

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			n_fail++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// apb transfer, entered just after a rising edge; result left in q and err
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n >= 50) n_fail++;
		q = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask

	// device register access; polls busy so only one request is ever pending
	task automatic dev(input logic w, input logic [1:0] a, input logic [7:0] d);
		int n;
		n = 0;
		apb(1'b1, rtc_timer_pkg::HOST_CMD_OFS, {15'h0000, w, 6'h00, a, d});
		do begin
			apb(1'b0, rtc_timer_pkg::HOST_STAT_OFS, 32'h0000_0000);
			n++;
		end while (q[rtc_timer_pkg::HSTAT_BUSY_BIT] !== 1'b0 && n < 40);
		if (n >= 40) n_fail++;
	endtask

	task automatic rd(input logic [1:0] a, input logic [7:0] exp);
		dev(1'b0, a, 8'h00);
		chk({24'h000000, q[15:8]}, {24'h000000, exp});
	endtask

	// bounded wait for the interrupt line to be pulled low
	task automatic wait_irq(input int lim);
		int n;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (link.irq_oe !== 1'b1 && n < lim);
		if (n >= lim) n_fail++;
	endtask

	task automatic t_map();
		rd(rtc_timer_pkg::ADDR_CTRL, rtc_timer_pkg::CTRL_RESET);
		rd(rtc_timer_pkg::ADDR_COUNT, 8'h00);
		rd(2'h3, 8'h00);
		apb(1'b0, 12'h008, 32'h0000_0000);
		chk({31'h0, err}, 32'h1);
		chk(q, 32'h0);
		$display("test map done");
	endtask

	// count writes land at once; run starts on the slowest source, so no tick is dropped
	task automatic t_load();
		dev(1'b1, rtc_timer_pkg::ADDR_CTRL, 8'h0f);
		dev(1'b1, rtc_timer_pkg::ADDR_COUNT, 8'h03);
		rd(rtc_timer_pkg::ADDR_COUNT, 8'h03);
		dev(1'b1, rtc_timer_pkg::ADDR_CTRL, 8'h09);
		dev(1'b1, rtc_timer_pkg::ADDR_COUNT, 8'h01);
		rd(rtc_timer_pkg::ADDR_COUNT, 8'h01);
		rd(rtc_timer_pkg::ADDR_COUNT, 8'h01);
		$display("test load done");
	endtask

	task automatic t_level();
		wait_irq(TICK + 2000);
		chk({31'h0, expiry_flag}, 32'h1);
		rd(rtc_timer_pkg::ADDR_COUNT, 8'h01);
		chk({31'h0, q[rtc_timer_pkg::HSTAT_IRQ_BIT]}, 32'h1);
		dev(1'b0, rtc_timer_pkg::ADDR_STAT, 8'h00);
		chk({31'h0, q[8]}, 32'h1);
		repeat (300) @(posedge pclk);
		chk({31'h0, link.irq_n}, 32'h0);
		dev(1'b1, rtc_timer_pkg::ADDR_STAT, 8'h01);
		chk({31'h0, link.irq_n}, 32'h1);
		chk({31'h0, expiry_flag}, 32'h0);
		$display("test level done");
	endtask

	// flag left set on purpose: pulses must keep coming, one tick apart
	task automatic t_pulse();
		int t0;
		int w;
		w = 0;
		dev(1'b1, rtc_timer_pkg::ADDR_CTRL, 8'h19);
		wait_irq(TICK + 2000);
		t0 = cyc;
		do begin
			@(posedge pclk);
			w++;
		end while (link.irq_oe === 1'b1 && w < 1000);
		chk(w, rtc_timer_pkg::IRQ_PULSE_CYCLES);
		wait_irq(TICK + 2000);
		chk(cyc - t0, TICK);
		chk({31'h0, expiry_flag}, 32'h1);
		$display("test pulse done");
	endtask

	task automatic t_stop();
		dev(1'b1, rtc_timer_pkg::ADDR_CTRL, 8'h18);
		dev(1'b1, rtc_timer_pkg::ADDR_COUNT, 8'h05);
		repeat (TICK + 200) @(posedge pclk);
		rd(rtc_timer_pkg::ADDR_COUNT, 8'h05);
		$display("test stop done");
	endtask

	task automatic stop_test();
		$display("checks %0d mismatches %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	// main sequence
	initial begin
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		t_map();
		t_load();
		t_level();
		t_pulse();
		t_stop();
		stop_test();
	end

	// watchdog just past the four ticks the tests need, so a hang stays near 100k cycles
	initial begin
		repeat (4 * TICK + 4000) @(posedge pclk);
		n_fail++;
		stop_test();
	end
endmodule
